// >>> lcd_pkg.sv
/*
 * Shared constants, register map and types for the LUT4 / 16-bit
 * counter-delay macrocell. Assumes nothing of its surroundings.
 */
`default_nettype none
package lcd_pkg;

	// ----------------------------------------------------------------
	// Bus and datapath widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned BUS_W  = 32;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned CNT_W  = 17;
	localparam int unsigned CTRL_W = 10;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DATA   = 8'h04;
	localparam logic [7:0] OFS_COUNT  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;

	// ----------------------------------------------------------------
	// Control field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_FUNC    = 0;
	localparam int unsigned CTRL_EDGE_LO = 1;
	localparam int unsigned CTRL_SRC_LO  = 3;
	localparam int unsigned CTRL_PRESET  = 6;
	localparam int unsigned CTRL_MODE_LO = 7;
	localparam int unsigned CTRL_FSM     = 9;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0001;
	localparam logic [CNT_W-1:0]  CNT_RST  = 17'h00000;
	localparam logic [CNT_W-1:0]  CNT_ONE  = 17'h00001;

	// ----------------------------------------------------------------
	// Prescaler terminal counts: divide by 4, 12, 24, 64
	// ----------------------------------------------------------------
	localparam int unsigned DIV_NUM = 4;
	localparam logic [5:0] DIV_LAST [DIV_NUM] =
		'{6'h03, 6'h0b, 6'h17, 6'h3f};
	localparam logic [5:0] DIV_RST = 6'h00;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DELAY   = 2'b00,
		MODE_ONESHOT = 2'b01,
		MODE_FREQ    = 2'b10,
		MODE_COUNT   = 2'b11
	} lcd_mode_e;

	typedef enum logic [1:0] {
		EDGE_BOTH  = 2'b00,
		EDGE_FALL  = 2'b01,
		EDGE_RISE  = 2'b10,
		EDGE_LEVEL = 2'b11
	} lcd_edge_e;

	typedef enum logic [2:0] {
		SRC_OSC    = 3'b000,
		SRC_DIV4   = 3'b001,
		SRC_DIV12  = 3'b010,
		SRC_DIV24  = 3'b011,
		SRC_DIV64  = 3'b100,
		SRC_FAST   = 3'b101,
		SRC_EXT    = 3'b110,
		SRC_CHAIN  = 3'b111
	} lcd_src_e;

	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_RUN  = 1'b1
	} lcd_phase_e;

	// Selected-edge decode, shared by datapath and checks
	function automatic logic lcd_edge_hit(input logic [1:0] e,
		input logic r, input logic f);
		logic hit;
		hit = 1'b0;
		case (e)
			EDGE_BOTH: hit = r | f;
			EDGE_FALL: hit = f;
			EDGE_RISE: hit = r;
			default:   hit = 1'b0;
		endcase
		return hit;
	endfunction

endpackage
`default_nettype wire

// >>> lcd_clk_sel.sv
/*
 * Count-clock selector: prescalers of the system clock plus the fast
 * oscillator tick, external clock edge and chained overflow.
 * Assumes all tick inputs are one-cycle pulses synchronous to clk.
 */
`default_nettype none
module lcd_clk_sel (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [2:0] src,
	input  wire logic       ext_rise,
	input  wire logic       fast_tick,
	input  wire logic       prev_ovf,
	output logic            tick
);
	import lcd_pkg::*;

	typedef struct packed {
		logic [DIV_NUM-1:0][5:0] cnt;
	} lcd_div_s;

	lcd_div_s             st_r;
	lcd_div_s             st_nxt;
	logic [DIV_NUM-1:0]   div_tick;

	// ----------------------------------------------------------------
	// Prescaler taps
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < DIV_NUM; g++) begin : g_div
			assign div_tick[g] = (st_r.cnt[g] == DIV_LAST[g]);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < DIV_NUM; i++) begin
			st_nxt.cnt[i] = div_tick[i] ? DIV_RST : st_r.cnt[i] + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Source mux
	// ----------------------------------------------------------------
	always_comb begin
		case (src)
			SRC_OSC:   tick = 1'b1;
			SRC_DIV4:  tick = div_tick[0];
			SRC_DIV12: tick = div_tick[1];
			SRC_DIV24: tick = div_tick[2];
			SRC_DIV64: tick = div_tick[3];
			SRC_FAST:  tick = fast_tick;
			SRC_EXT:   tick = ext_rise;
			default:   tick = prev_ovf;
		endcase
	end

endmodule
`default_nettype wire

// >>> lcd_apb.sv
/*
 * APB slave holding the configuration and control-data registers and
 * reading back the live count and status. Assumes an APB3 master.
 */
`default_nettype none
module lcd_apb (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [lcd_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [lcd_pkg::BUS_W-1:0]   pwdata,
	output logic      [lcd_pkg::BUS_W-1:0]   prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [lcd_pkg::DATA_W-1:0]  count_val,
	input  wire logic [1:0]                  status,
	output logic      [lcd_pkg::CTRL_W-1:0]  ctrl,
	output logic      [lcd_pkg::DATA_W-1:0]  data
);
	import lcd_pkg::*;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [DATA_W-1:0] data;
		logic [BUS_W-1:0]  prdata;
		logic              pready;
		logic              pslverr;
	} lcd_apb_s;

	lcd_apb_s st_r;
	lcd_apb_s st_nxt;
	logic     access;
	logic     commit;

	function automatic logic lcd_addr_ok(input logic [ADDR_W-1:0] a);
		return (a == OFS_CTRL) || (a == OFS_DATA) ||
			(a == OFS_COUNT) || (a == OFS_STATUS);
	endfunction

	// One wait state: ready rises in the second access cycle
	assign access = psel & penable & ~st_r.pready;
	assign commit = psel & penable & st_r.pready & pwrite;

	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = access;
		st_nxt.pslverr = access & ~lcd_addr_ok(paddr);
		if (access) begin
			case (paddr)
				OFS_CTRL:   st_nxt.prdata = {22'h000000, st_r.ctrl};
				OFS_DATA:   st_nxt.prdata = {16'h0000, st_r.data};
				OFS_COUNT:  st_nxt.prdata = {16'h0000, count_val};
				OFS_STATUS: st_nxt.prdata = {30'h00000000, status};
				default:    st_nxt.prdata = 32'h00000000;
			endcase
		end
		if (commit && paddr == OFS_CTRL) begin
			st_nxt.ctrl = pwdata[CTRL_W-1:0];
		end
		if (commit && paddr == OFS_DATA) begin
			st_nxt.data = pwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '{ctrl: CTRL_RST, data: DATA_RST, prdata: '0,
				pready: 1'b0, pslverr: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata  = st_r.prdata;
	assign pready  = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign ctrl    = st_r.ctrl;
	assign data    = st_r.data;

endmodule
`default_nettype wire

// >>> lcd_top.sv
/*
 * Dual-function macrocell: 4-input lookup table or 16-bit
 * counter / delay / one-shot / frequency detector with optional
 * up-down-pause control. Assumes matrix inputs, the fast oscillator
 * tick and the chained overflow are synchronous to clk.
 */
`default_nettype none
// Function
// - Function bit picks table or counter
// - Table output is truth bit at input index
// - Inputs: clock, delay/clear, keep, up
// - Counting is downward by default
// - Up input reverses direction in state mode
// - Keep high holds count, resumes afterwards
// - Edge field selects delay/clear edges
// - Clock-source field selects count tick
// - Preset bit: clear to zero or data
// - Mode field: delay, one-shot, frequency, counter
// - Control data sets delay, period, width
// - Delay lasts data plus two ticks
// - Counter period is data plus one
// - One-shot width is data plus two
// - Frequency detect mode is supported
// - Live count readable by software
// - One-shot ignores edges while pulsing
// - Frequency output high on close edges
// - Delay mode filters short pulses
module lcd_top (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [lcd_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [lcd_pkg::BUS_W-1:0]   pwdata,
	output logic      [lcd_pkg::BUS_W-1:0]   prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [3:0]                  matrix_in,
	input  wire logic                        fast_osc_tick,
	input  wire logic                        prev_overflow,
	output logic                             cell_out,
	output logic                             overflow_out
);
	import lcd_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		lcd_phase_e       phase;
		logic             out;
		logic             ovf;
		logic             din_prev;
		logic             ext_prev;
		logic             target;
	} lcd_core_s;

	lcd_core_s          st_r;
	lcd_core_s          st_nxt;
	logic [CTRL_W-1:0]  ctrl;
	logic [DATA_W-1:0]  ctrl_data;
	logic               func_cnt;
	logic [1:0]         edge_sel;
	logic [2:0]         src_sel;
	logic               preset_sel;
	lcd_mode_e          mode;
	logic               state_machine_function;
	logic               ext_clk;
	logic               delay_in_or_count_clear;
	logic               keep_in;
	logic               up_in;
	logic               din_rise;
	logic               din_fall;
	logic               ext_rise;
	logic               sel_ev;
	logic               lvl_clr;
	logic               clr_any;
	logic               tick;
	logic               tick_run;
	logic               up_eff;
	logic [CNT_W-1:0]   data_ext;
	logic [CNT_W-1:0]   data_p1;
	logic [CNT_W-1:0]   preset_val;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	lcd_apb u_apb (
		.clk       (clk),
		.rstn      (rstn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.count_val (st_r.cnt[DATA_W-1:0]),
		.status    ({st_r.phase, st_r.out}),
		.ctrl      (ctrl),
		.data      (ctrl_data)
	);

	// Fields are read live; software must not retune while counting
	assign func_cnt   = ctrl[CTRL_FUNC];
	assign edge_sel   = ctrl[CTRL_EDGE_LO+:2];
	assign src_sel    = ctrl[CTRL_SRC_LO+:3];
	assign preset_sel = ctrl[CTRL_PRESET];
	assign mode       = lcd_mode_e'(ctrl[CTRL_MODE_LO+:2]);
	assign state_machine_function = ctrl[CTRL_FSM];

	// ----------------------------------------------------------------
	// Matrix inputs and edge detection
	// ----------------------------------------------------------------
	assign ext_clk                 = matrix_in[0];
	assign delay_in_or_count_clear = matrix_in[1];
	assign keep_in                 = matrix_in[2];
	assign up_in                   = matrix_in[3];

	assign din_rise = delay_in_or_count_clear & ~st_r.din_prev;
	assign din_fall = ~delay_in_or_count_clear & st_r.din_prev;
	assign ext_rise = ext_clk & ~st_r.ext_prev;
	assign sel_ev   = lcd_edge_hit(edge_sel, din_rise, din_fall);
	assign lvl_clr  = (edge_sel == EDGE_LEVEL) & delay_in_or_count_clear;
	assign clr_any  = sel_ev | lvl_clr;

	// ----------------------------------------------------------------
	// Count tick
	// ----------------------------------------------------------------
	lcd_clk_sel u_clk_sel (
		.clk       (clk),
		.rstn      (rstn),
		.src       (src_sel),
		.ext_rise  (ext_rise),
		.fast_tick (fast_osc_tick),
		.prev_ovf  (prev_overflow),
		.tick      (tick)
	);

	assign tick_run   = tick & ~keep_in;
	assign up_eff     = state_machine_function & up_in;
	assign data_ext   = {1'b0, ctrl_data};
	assign data_p1    = data_ext + CNT_ONE;
	assign preset_val = preset_sel ? data_ext : CNT_RST;

	// ----------------------------------------------------------------
	// Core next state
	// ----------------------------------------------------------------
	// Timed modes load data+1 and expire on the tick at zero, so the
	// output moves data+2 ticks after the edge; one spare count bit
	// keeps data = 65535 from wrapping.
	always_comb begin
		st_nxt          = st_r;
		st_nxt.din_prev = delay_in_or_count_clear;
		st_nxt.ext_prev = ext_clk;
		st_nxt.ovf      = 1'b0;
		if (!func_cnt) begin
			st_nxt.out   = ctrl_data[matrix_in];
			st_nxt.phase = PH_IDLE;
		end else begin
			case (mode)
				MODE_COUNT: begin
					st_nxt.phase = PH_IDLE;
					if (clr_any) begin
						st_nxt.cnt = preset_val;
					end else if (tick_run && up_eff) begin
						if (st_r.cnt == data_ext) begin
							st_nxt.cnt = CNT_RST;
							st_nxt.ovf = 1'b1;
						end else begin
							st_nxt.cnt = st_r.cnt + CNT_ONE;
						end
					end else if (tick_run) begin
						if (st_r.cnt == CNT_RST) begin
							st_nxt.cnt = data_ext;
							st_nxt.ovf = 1'b1;
						end else begin
							st_nxt.cnt = st_r.cnt - CNT_ONE;
						end
					end
					st_nxt.out = st_nxt.ovf;
				end
				MODE_DELAY: begin
					if (sel_ev) begin
						// Restart drops a pending edge: short pulses vanish
						st_nxt.phase  = PH_RUN;
						st_nxt.cnt    = data_p1;
						st_nxt.target = delay_in_or_count_clear;
					end else if (din_rise || din_fall) begin
						st_nxt.phase = PH_IDLE;
						st_nxt.out   = delay_in_or_count_clear;
					end else if (st_r.phase == PH_RUN && tick_run) begin
						if (st_r.cnt == CNT_RST) begin
							st_nxt.phase = PH_IDLE;
							st_nxt.out   = st_r.target;
							st_nxt.ovf   = 1'b1;
						end else begin
							st_nxt.cnt = st_r.cnt - CNT_ONE;
						end
					end
				end
				MODE_ONESHOT: begin
					if (st_r.phase == PH_IDLE) begin
						if (sel_ev) begin
							st_nxt.phase = PH_RUN;
							st_nxt.cnt   = data_p1;
							st_nxt.out   = 1'b1;
						end
					end else if (tick_run) begin
						// Edges are not looked at while running
						if (st_r.cnt == CNT_RST) begin
							st_nxt.phase = PH_IDLE;
							st_nxt.out   = 1'b0;
							st_nxt.ovf   = 1'b1;
						end else begin
							st_nxt.cnt = st_r.cnt - CNT_ONE;
						end
					end
				end
				default: begin
					// Frequency detect: window restarts on each selected edge
					if (sel_ev) begin
						if (st_r.phase == PH_RUN) begin
							st_nxt.out = 1'b1;
						end
						st_nxt.phase = PH_RUN;
						st_nxt.cnt   = data_p1;
					end else if (st_r.phase == PH_RUN && tick_run) begin
						if (st_r.cnt == CNT_RST) begin
							st_nxt.phase = PH_IDLE;
							st_nxt.out   = 1'b0;
							st_nxt.ovf   = 1'b1;
						end else begin
							st_nxt.cnt = st_r.cnt - CNT_ONE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '{cnt: CNT_RST, phase: PH_IDLE, out: 1'b0, ovf: 1'b0,
				din_prev: 1'b0, ext_prev: 1'b0, target: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cell_out     = st_r.out;
	assign overflow_out = st_r.ovf;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic cnt_mode;
	assign cnt_mode = func_cnt && mode == MODE_COUNT;

	AST_LUT_OUT: assert property (
		!func_cnt |=> cell_out == $past(ctrl_data[matrix_in]))
		else $error("table output wrong");
	AST_DOWN: assert property (
		cnt_mode && !clr_any && tick_run && !up_eff && st_r.cnt != CNT_RST
		|=> st_r.cnt == $past(st_r.cnt) - CNT_ONE)
		else $error("down count wrong");
	AST_UP: assert property (
		cnt_mode && !clr_any && tick_run && up_eff && st_r.cnt != data_ext
		|=> st_r.cnt == $past(st_r.cnt) + CNT_ONE)
		else $error("up count wrong");
	AST_KEEP: assert property (
		func_cnt && keep_in && !(cnt_mode && clr_any) && !sel_ev
		&& !(din_rise || din_fall) |=> $stable(st_r.cnt))
		else $error("keep did not hold");
	AST_PRESET: assert property (
		cnt_mode && clr_any |=> st_r.cnt == $past(preset_val))
		else $error("preset value wrong");
	AST_TERM: assert property (
		cnt_mode && !clr_any && tick_run && !up_eff && st_r.cnt == CNT_RST
		|=> overflow_out && cell_out && st_r.cnt == $past(data_ext))
		else $error("terminal reload wrong");
	AST_OS_START: assert property (
		func_cnt && mode == MODE_ONESHOT && st_r.phase == PH_IDLE && sel_ev
		|=> cell_out && st_r.phase == PH_RUN && st_r.cnt == $past(data_p1))
		else $error("one-shot did not start");
	AST_OS_IGNORE: assert property (
		func_cnt && mode == MODE_ONESHOT && st_r.phase == PH_RUN && sel_ev
		&& !tick_run |=> $stable(st_r.cnt) && cell_out)
		else $error("one-shot restarted");
	AST_FD_HIGH: assert property (
		func_cnt && mode == MODE_FREQ && st_r.phase == PH_RUN && sel_ev
		|=> cell_out)
		else $error("frequency output not high");
	AST_DLY_EXP: assert property (
		func_cnt && mode == MODE_DELAY && st_r.phase == PH_RUN && tick_run
		&& st_r.cnt == CNT_RST && !din_rise && !din_fall
		|=> cell_out == $past(st_r.target) && st_r.phase == PH_IDLE)
		else $error("delay expiry wrong");
	AST_SRC_DIV: assert property (
		src_sel == SRC_DIV4 && tick ##1 src_sel == SRC_DIV4 |-> !tick)
		else $error("divided tick too close");

	COV_OVF: cover property (cnt_mode ##1 overflow_out);
	COV_OS: cover property (cell_out && mode == MODE_ONESHOT ##1 !cell_out);
	COV_FD: cover property (mode == MODE_FREQ && func_cnt ##1 cell_out);
	COV_DLY: cover property (mode == MODE_DELAY && func_cnt && overflow_out);

endmodule
`default_nettype wire

// >>> lcd_matrix_model.sv
/*
 * Connection-matrix side model: input levels from the bench, a free
 * external clock, the 25 MHz tick and a neighbour overflow pulse.
 * Assumes the bench changes lv and ext_on just after rising edges.
 */
`default_nettype none
module lcd_matrix_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [3:0] lv,
	input  wire logic       ext_on,
	output logic      [3:0] matrix_in,
	output logic            fast_osc_tick,
	output logic            prev_overflow
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Shared phase counter
	// ----------------------------------------------------------------
	// Wraps at 60 so ticks of 4, 5 and 6 stay periodic
	logic [7:0] n_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			n_r <= 8'h00;
		end else begin
			n_r <= (n_r == 8'h3b) ? 8'h00 : n_r + 8'h01;
		end
	end
	assign fast_osc_tick = (n_r[1:0] == 2'h3);
	assign prev_overflow = (n_r % 5 == 0);
	// Ext clock period of six cycles, only while enabled
	assign matrix_in = {lv[3:1], ext_on ? ((n_r % 6) < 3) : lv[0]};
endmodule
`default_nettype wire

// >>> lcd_top_tb.sv
/*
 * Self-checking bench for lcd_top: APB master tasks, matrix model,
 * one random truth word. Assumes the hand-over APB timing.
 */
`default_nettype none
module lcd_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lcd_pkg::*;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic        clk, rstn, psel, penable, pwrite, ext_on, se;
	logic        pready, pslverr, cell_out, overflow_out;
	logic        fast_osc_tick, prev_overflow;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  lv, matrix_in;
	int          err_total, tests_run, hi, up, t0, t1, k;
	int          div_tab [8] = '{1, 4, 12, 24, 64, 4, 6, 5};
	int          os_up [4] = '{2, 1, 1, 0};

	lcd_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .matrix_in(matrix_in),
		.fast_osc_tick(fast_osc_tick), .prev_overflow(prev_overflow),
		.cell_out(cell_out), .overflow_out(overflow_out));
	lcd_matrix_model mdl (.clk(clk), .rstn(rstn), .lv(lv),
		.ext_on(ext_on), .matrix_in(matrix_in),
		.fast_osc_tick(fast_osc_tick), .prev_overflow(prev_overflow));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// Holds the whole request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so the next call never re-raises psel in this step
		@(posedge clk);
		if (n >= 20) begin
			err_total++;
			tally_and_finish();
		end
	endtask

	function automatic logic [31:0] cw(input logic [1:0] e,
		input logic [2:0] s, input logic p, input logic [1:0] m,
		input logic f);
		return {22'h0, f, m, p, s, e, 1'b1};
	endfunction

	task automatic cfg(input logic [31:0] c, input logic [15:0] d);
		apb(1'b1, OFS_DATA, {16'h0, d});
		apb(1'b1, OFS_CTRL, c);
	endtask

	task automatic watch(input int n);
		logic p;
		hi = 0;
		up = 0;
		t0 = 0;
		p = cell_out;
		for (int i = 1; i <= n; i++) begin
			@(posedge clk);
			hi += int'(cell_out === 1'b1);
			if (cell_out === 1'b1 && p !== 1'b1) begin
				up++;
				if (t0 == 0) t0 = i;
			end
			p = cell_out;
		end
	endtask

	task automatic pulse(input int w, input int g, input int n);
		repeat (n) begin
			lv <= 4'h2;
			repeat (w) @(posedge clk);
			lv <= 4'h0;
			repeat (g) @(posedge clk);
		end
	endtask

	// Second gap between overflow pulses, so a config change settles
	task automatic per(output int p);
		int n;
		for (int i = 0; i < 3; i++) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (overflow_out !== 1'b1 && n < 2000);
			if (n >= 2000) begin
				err_total++;
				tally_and_finish();
			end
			p = n;
		end
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lv = 4'h0;
		ext_on = 1'b0;
		err_total = 0;
		tests_run = 0;
		k = $urandom(32'h3974);
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0, q);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("data", 32'h1, q);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, {31'h0, se});
		t1 = $urandom;
		apb(1'b1, OFS_DATA, {16'h0, t1[15:0]});
		repeat (24) begin
			k = $urandom % 16;
			lv <= k[3:0];
			repeat (2) @(posedge clk);
			chk("table", {31'h0, t1[k]}, {31'h0, cell_out});
		end
		// Random level may leave keep high and stall the counter
		lv <= 4'h0;
		for (int s = 0; s < 8; s++) begin
			ext_on <= (s == 6);
			cfg(cw(2'h2, s[2:0], 1'b1, 2'h3, 1'b0), 16'h3);
			per(k);
			chk("period", div_tab[s] * 4, k);
		end
		lv <= 4'h2;
		apb(1'b1, OFS_CTRL, cw(2'h3, 3'h0, 1'b1, 2'h3, 1'b0));
		repeat (3) @(posedge clk);
		watch(30);
		chk("level clear", 32'h0, up);
		lv <= 4'h4;
		cfg(cw(2'h2, 3'h4, 1'b1, 2'h3, 1'b1), 16'd1000);
		lv <= 4'h6;
		@(posedge clk);
		lv <= 4'h4;
		repeat (300) @(posedge clk);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("kept", 32'd1000, q);
		lv <= 4'h0;
		repeat (640) @(posedge clk);
		apb(1'b0, OFS_COUNT, 32'h0);
		t0 = q;
		chk("down", 32'h1, {31'h0, t0 < 1000 && t0 > 985});
		lv <= 4'h8;
		repeat (320) @(posedge clk);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("up", 32'h1, {31'h0, q > t0 && q < 1000});
		lv <= 4'h4;
		apb(1'b1, OFS_CTRL, cw(2'h2, 3'h4, 1'b0, 2'h3, 1'b1));
		lv <= 4'h6;
		@(posedge clk);
		lv <= 4'h4;
		repeat (4) @(posedge clk);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("cleared", 32'h0, q);
		// Keep high: no overflow pulse can be frozen into the output
		lv <= 4'h4;
		// Last pass leaves both edges selected for the retrigger case
		for (int e = 3; e >= 0; e--) begin
			cfg(cw(e[1:0], 3'h0, 1'b0, 2'h1, 1'b0), 16'h3);
			repeat (10) @(posedge clk);
			fork
				pulse(20, 1, 1);
				watch(50);
			join
			chk("shots", os_up[e], up);
			chk("width", up * 5, hi);
		end
		t1 = t0;
		fork
			pulse(2, 1, 1);
			watch(30);
		join
		chk("retrigger", 5, hi);
		cfg(cw(2'h0, 3'h0, 1'b0, 2'h0, 1'b0), 16'h3);
		repeat (10) @(posedge clk);
		fork
			pulse(3, 1, 1);
			watch(30);
		join
		chk("filtered", 0, hi);
		fork
			pulse(20, 1, 1);
			watch(50);
		join
		chk("delayed", 20, hi);
		chk("lag", 1, int'(t0 - t1 == 5));
		cfg(cw(2'h2, 3'h0, 1'b0, 2'h2, 1'b0), 16'd10);
		repeat (20) @(posedge clk);
		fork
			pulse(2, 28, 3);
			watch(90);
		join
		chk("slow", 0, hi);
		fork
			pulse(2, 3, 6);
			watch(60);
		join
		chk("fast", 1, up);
		chk("expired", 32'h0, {31'h0, cell_out});
		tally_and_finish();
	end
endmodule
`default_nettype wire
